// >>> src/vsra_pkg.sv
package vsra_pkg;

    // Register bus geometry
    localparam int          AXI_AW           = 12;
    localparam logic [11:0] ADDR_VERSION     = 12'h000;
    localparam logic [11:0] ADDR_ROM_ACCESS  = 12'h004;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // Field positions
    localparam int          BIT_ADDR_CLEAR   = 31;
    localparam int          BIT_READ_KICK    = 25;
    localparam int          BIT_PRESENT      = 24;
    localparam int          BYTE_LSB         = 16;
    localparam int          STRB_TOP_LANE    = 3;
    localparam int          STRB_BYTE_LANE   = 2;

    // Fixed version contents
    localparam logic [6:0]  VER_TOP_ZERO     = 7'h00;
    localparam logic [7:0]  VER_MAJOR        = 8'h01;
    localparam logic [7:0]  VER_MID_ZERO     = 8'h00;
    localparam logic [7:0]  VER_MINOR        = 8'h00;

    // Serial ROM geometry and boot image
    localparam int          ROM_AW           = 8;
    localparam int          HDR_BYTES        = 16;
    localparam int          CFG_BYTES        = 4;
    localparam logic [4:0]  HDR_LAST         = 5'h0F;
    localparam logic [4:0]  BOOT_LAST        = 5'h13;

    // Cycles to let the presence synchroniser settle after reset
    localparam logic [2:0]  SETTLE_CYCLES    = 3'h5;

    // Values after reset
    localparam logic [7:0]  RST_ADDR         = 8'h00;
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [4:0]  RST_IDX          = 5'h00;
    localparam logic [2:0]  RST_SETTLE       = 3'h0;
    localparam logic [31:0] RST_WORD         = 32'h00000000;

    typedef enum logic [1:0] {
        VSRA_IDLE = 2'h0,
        VSRA_REQ  = 2'h1,
        VSRA_REL  = 2'h3
    } vsra_state_t;

    // Toward the ROM: request level and byte address
    typedef struct packed {
        logic              req;
        logic [ROM_AW-1:0] addr;
    } vsra_rom_req_t;

    // From the ROM: acknowledge level and byte
    typedef struct packed {
        logic       ack;
        logic [7:0] data;
    } vsra_rom_rsp_t;

endpackage : vsra_pkg

// >>> src/vsra_top.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Version bits 31:25 read zero
// - Bit 24 shows serial ROM present
// - Present ROM auto-loads header, config after reset
// - Version bits 23:16 read 01h
// - Version bits 15:8 read zero
// - Version bits 7:0 read 00h
// - Writing one to bit 31 zeroes address
// - Device clears bit 31 when done
// - Writing one to bit 25 starts read
// - Device clears bit 25 after read
// - Byte in 23:16, valid while 25 zero
// - Unused ROM register bits read zero
module vsra_top (
    input  wire logic                       core_clk,       // 20 MHz clock
    input  wire logic                       rst_b,          // Async reset, low
    input  wire logic [vsra_pkg::AXI_AW-1:0] s_axi_awaddr,  // Write address
    input  wire logic                       s_axi_awvalid,  // Write address valid
    output logic                            s_axi_awready,  // Write address ready
    input  wire logic [31:0]                s_axi_wdata,    // Write data
    input  wire logic [3:0]                 s_axi_wstrb,    // Write strobes
    input  wire logic                       s_axi_wvalid,   // Write data valid
    output logic                            s_axi_wready,   // Write data ready
    output logic [1:0]                      s_axi_bresp,    // Write response
    output logic                            s_axi_bvalid,   // Write response valid
    input  wire logic                       s_axi_bready,   // Write response ready
    input  wire logic [vsra_pkg::AXI_AW-1:0] s_axi_araddr,  // Read address
    input  wire logic                       s_axi_arvalid,  // Read address valid
    output logic                            s_axi_arready,  // Read address ready
    output logic [31:0]                     s_axi_rdata,    // Read data
    output logic [1:0]                      s_axi_rresp,    // Read response
    output logic                            s_axi_rvalid,   // Read data valid
    input  wire logic                       s_axi_rready,   // Read data ready
    input  wire logic                       rom_detect,     // ROM fitted strap pin
    input  vsra_pkg::vsra_rom_rsp_t         rom_rsp,        // ROM ack and byte pins
    output vsra_pkg::vsra_rom_req_t         rom_out,        // ROM request and address
    output logic [8*vsra_pkg::HDR_BYTES-1:0] node_header,   // Loaded header bytes
    output logic [8*vsra_pkg::CFG_BYTES-1:0] chip_config,   // Loaded config bytes
    output logic                            boot_done       // Boot load finished
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    vsra_pkg::vsra_rom_rsp_t rsp_s1_q, rsp_s2_q, rsp_s3_q;
    logic                    det_s1_q, det_s2_q, det_s3_q;
    logic                    ack_f_q;
    logic                    rom_present_flag_q;
    vsra_pkg::vsra_state_t   state_q;
    vsra_pkg::vsra_rom_req_t rom_out_q;
    logic                    rom_address_clear_q;
    logic                    rom_read_kick_q;
    logic [7:0]              rom_read_byte_q;
    logic [2:0]              settle_q;
    logic                    boot_active_q;
    logic                    boot_done_q;
    logic [4:0]              boot_idx_q;
    logic [8*vsra_pkg::HDR_BYTES-1:0] node_header_q;
    logic [8*vsra_pkg::CFG_BYTES-1:0] chip_config_q;

    logic [vsra_pkg::AXI_AW-1:0] awaddr_q;
    logic                    aw_have_q, aw_have_d;
    logic                    w_have_q, w_have_d;
    logic [31:0]             wdata_q;
    logic [3:0]              wstrb_q;
    logic                    awready_q, wready_q;
    logic                    bvalid_q, bvalid_d;
    logic [1:0]              bresp_q;
    logic                    arready_q;
    logic                    rvalid_q, rvalid_d;
    logic [31:0]             rdata_q;
    logic [1:0]              rresp_q;

    logic                    aw_hs, w_hs, wr_go, ar_hs;
    logic                    wr_access;
    logic                    set_clear, set_kick;
    logic                    start_rd, got_byte, fin_rd, clr_done, boot_end;
    logic [31:0]             version_word, access_word;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, ack and detect change accepted when stages two and three agree

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_s1_q <= '0;
            rsp_s2_q <= '0;
            rsp_s3_q <= '0;
            det_s1_q <= 1'b0;
            det_s2_q <= 1'b0;
            det_s3_q <= 1'b0;
        end else begin
            rsp_s1_q <= rom_rsp;
            rsp_s2_q <= rsp_s1_q;
            rsp_s3_q <= rsp_s2_q;
            det_s1_q <= rom_detect;
            det_s2_q <= det_s1_q;
            det_s3_q <= det_s2_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_f_q            <= 1'b0;
            rom_present_flag_q <= 1'b0;
        end else begin
            if (rsp_s2_q.ack == rsp_s3_q.ack) begin
                ack_f_q <= rsp_s3_q.ack;
            end
            if (det_s2_q == det_s3_q) begin
                rom_present_flag_q <= det_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read sequencer events

    always_comb begin
        start_rd = (state_q == vsra_pkg::VSRA_IDLE)
                 & (boot_active_q | (rom_read_kick_q & ~rom_address_clear_q));
        got_byte = (state_q == vsra_pkg::VSRA_REQ) & ack_f_q;
        fin_rd   = (state_q == vsra_pkg::VSRA_REL) & ~ack_f_q;
        clr_done = (state_q == vsra_pkg::VSRA_IDLE) & ~boot_active_q & rom_address_clear_q;
        boot_end = fin_rd & boot_active_q & (boot_idx_q == vsra_pkg::BOOT_LAST);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= vsra_pkg::VSRA_IDLE;
        end else begin
            unique case (state_q)
                vsra_pkg::VSRA_IDLE: begin
                    if (start_rd) begin
                        state_q <= vsra_pkg::VSRA_REQ;
                    end
                end
                vsra_pkg::VSRA_REQ: begin
                    if (ack_f_q) begin
                        state_q <= vsra_pkg::VSRA_REL;
                    end
                end
                vsra_pkg::VSRA_REL: begin
                    if (!ack_f_q) begin
                        state_q <= vsra_pkg::VSRA_IDLE;
                    end
                end
                default: begin
                    state_q <= vsra_pkg::VSRA_IDLE;
                end
            endcase
        end
    end

    // ROM port: request level and byte address
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rom_out_q.req  <= 1'b0;
            rom_out_q.addr <= vsra_pkg::RST_ADDR;
        end else begin
            if (start_rd) begin
                rom_out_q.req <= 1'b1;
            end else if (got_byte) begin
                rom_out_q.req <= 1'b0;
            end
            if (clr_done || boot_end) begin
                rom_out_q.addr <= vsra_pkg::RST_ADDR;
            end else if (fin_rd) begin
                rom_out_q.addr <= rom_out_q.addr + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Boot load after reset

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_q      <= vsra_pkg::RST_SETTLE;
            boot_active_q <= 1'b0;
            boot_done_q   <= 1'b0;
            boot_idx_q    <= vsra_pkg::RST_IDX;
        end else begin
            if (settle_q != vsra_pkg::SETTLE_CYCLES) begin
                settle_q <= settle_q + 3'h1;
            end
            // start load only if ROM present
            if (settle_q == (vsra_pkg::SETTLE_CYCLES - 3'h1)) begin
                boot_active_q <= rom_present_flag_q;
                boot_done_q   <= ~rom_present_flag_q;
            end else if (boot_end) begin
                boot_active_q <= 1'b0;
                boot_done_q   <= 1'b1;
            end
            if (fin_rd && boot_active_q) begin
                boot_idx_q <= boot_idx_q + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            node_header_q <= '0;
            chip_config_q <= vsra_pkg::RST_WORD;
        end else if (got_byte && boot_active_q) begin
            if (boot_idx_q <= vsra_pkg::HDR_LAST) begin
                node_header_q[8*boot_idx_q[3:0] +: 8] <= rsp_s3_q.data;
            end else begin
                chip_config_q[8*boot_idx_q[1:0] +: 8] <= rsp_s3_q.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software access bits

    always_comb begin
        wr_access = wr_go & (awaddr_q == vsra_pkg::ADDR_ROM_ACCESS);
        set_clear = wr_access & wstrb_q[vsra_pkg::STRB_TOP_LANE]
                  & wdata_q[vsra_pkg::BIT_ADDR_CLEAR];
        set_kick  = wr_access & wstrb_q[vsra_pkg::STRB_TOP_LANE]
                  & wdata_q[vsra_pkg::BIT_READ_KICK];
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rom_address_clear_q <= 1'b0;
        end else if (set_clear) begin
            rom_address_clear_q <= 1'b1;
        end else if (clr_done) begin
            rom_address_clear_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rom_read_kick_q <= 1'b0;
        end else if (set_kick) begin
            rom_read_kick_q <= 1'b1;
        end else if (fin_rd && !boot_active_q) begin
            rom_read_kick_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rom_read_byte_q <= vsra_pkg::RST_BYTE;
        end else if (got_byte && !boot_active_q) begin
            rom_read_byte_q <= rsp_s3_q.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read words

    always_comb begin
        version_word = {vsra_pkg::VER_TOP_ZERO, rom_present_flag_q, vsra_pkg::VER_MAJOR,
                        vsra_pkg::VER_MID_ZERO, vsra_pkg::VER_MINOR};
        access_word  = vsra_pkg::RST_WORD;
        access_word[vsra_pkg::BIT_ADDR_CLEAR]            = rom_address_clear_q;
        access_word[vsra_pkg::BIT_READ_KICK]             = rom_read_kick_q;
        access_word[vsra_pkg::BYTE_LSB +: 8]             = rom_read_byte_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    always_comb begin
        aw_hs     = s_axi_awvalid & awready_q;
        w_hs      = s_axi_wvalid & wready_q;
        wr_go     = aw_have_q & w_have_q & ~bvalid_q;
        aw_have_d = wr_go ? 1'b0 : (aw_have_q | aw_hs);
        w_have_d  = wr_go ? 1'b0 : (w_have_q | w_hs);
        bvalid_d  = wr_go ? 1'b1 : (bvalid_q & ~s_axi_bready);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= vsra_pkg::RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= vsra_pkg::RST_WORD;
            wstrb_q   <= 4'h0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awready_q <= ~aw_have_d & ~bvalid_d;
            wready_q  <= ~w_have_d & ~bvalid_d;
            bvalid_q  <= bvalid_d;
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                bresp_q <= (awaddr_q == vsra_pkg::ADDR_VERSION
                         || awaddr_q == vsra_pkg::ADDR_ROM_ACCESS)
                         ? vsra_pkg::RESP_OKAY : vsra_pkg::RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    always_comb begin
        ar_hs    = s_axi_arvalid & arready_q;
        rvalid_d = ar_hs ? 1'b1 : (rvalid_q & ~s_axi_rready);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= vsra_pkg::RST_WORD;
            rresp_q   <= vsra_pkg::RESP_OKAY;
        end else begin
            arready_q <= ~rvalid_d;
            rvalid_q  <= rvalid_d;
            if (ar_hs) begin
                unique case (s_axi_araddr)
                    vsra_pkg::ADDR_VERSION: begin
                        rdata_q <= version_word;
                        rresp_q <= vsra_pkg::RESP_OKAY;
                    end
                    vsra_pkg::ADDR_ROM_ACCESS: begin
                        rdata_q <= access_word;
                        rresp_q <= vsra_pkg::RESP_OKAY;
                    end
                    default: begin
                        rdata_q <= vsra_pkg::RST_WORD;
                        rresp_q <= vsra_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign rom_out       = rom_out_q;
    assign node_header   = node_header_q;
    assign chip_config   = chip_config_q;
    assign boot_done     = boot_done_q;

endmodule : vsra_top

// >>> tb/vsra_checker.sv
`timescale 1ns/1ps
module vsra_checker (
    input wire logic                        core_clk,      // Clock
    input wire logic                        rst_b,         // Reset, low
    input wire logic [vsra_pkg::AXI_AW-1:0] s_axi_awaddr,  // Write address
    input wire logic                        s_axi_awvalid, // Write addr valid
    input wire logic                        s_axi_awready, // Write addr ready
    input wire logic [1:0]                  s_axi_bresp,   // Write response
    input wire logic                        s_axi_bvalid,  // Write resp valid
    input wire logic [vsra_pkg::AXI_AW-1:0] s_axi_araddr,  // Read address
    input wire logic                        s_axi_arvalid, // Read addr valid
    input wire logic                        s_axi_arready, // Read addr ready
    input wire logic [31:0]                 s_axi_rdata,   // Read data
    input wire logic                        s_axi_rvalid,  // Read valid
    input wire logic                        rom_detect,    // ROM fitted
    input vsra_pkg::vsra_rom_rsp_t          rom_rsp,       // ROM answer
    input vsra_pkg::vsra_rom_req_t          rom_out,       // ROM request
    input wire logic                        boot_done      // Boot over
);
    logic [11:0] rd_addr_q;
    logic [11:0] wr_addr_q;
    logic        ver_rd;
    logic        rom_rd;
    logic        mapped;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) rd_addr_q <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) wr_addr_q <= 12'h000;
        else if (s_axi_awvalid && s_axi_awready) wr_addr_q <= s_axi_awaddr;
    end
    assign ver_rd = s_axi_rvalid && (rd_addr_q == vsra_pkg::ADDR_VERSION);
    assign rom_rd = s_axi_rvalid && (rd_addr_q == vsra_pkg::ADDR_ROM_ACCESS);
    assign mapped = wr_addr_q == vsra_pkg::ADDR_VERSION || wr_addr_q == vsra_pkg::ADDR_ROM_ACCESS;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    chk_ver_top_zero: assert property (ver_rd |-> s_axi_rdata[31:25] == 7'h00)
        else $error("version top bits not zero");
    chk_ver_present: assert property (ver_rd |-> s_axi_rdata[24] == rom_detect)
        else $error("present flag wrong");
    chk_ver_major: assert property (ver_rd |-> s_axi_rdata[23:16] == 8'h01)
        else $error("major version wrong");
    chk_ver_mid_zero: assert property (ver_rd |-> s_axi_rdata[15:8] == 8'h00)
        else $error("version mid bits not zero");
    chk_ver_minor: assert property (ver_rd |-> s_axi_rdata[7:0] == 8'h00)
        else $error("minor version wrong");
    chk_rom_unused_zero: assert property (rom_rd |->
        s_axi_rdata[30:26] == 5'h00 && !s_axi_rdata[24] && s_axi_rdata[15:0] == 16'h0000)
        else $error("unused access bits not zero");
    chk_req_holds: assert property (rom_out.req && !rom_rsp.ack |=> rom_out.req)
        else $error("request dropped before answer");
    chk_addr_step: assert property (boot_done && $changed(rom_out.addr) |->
        rom_out.addr == 8'h00 || rom_out.addr == 8'($past(rom_out.addr) + 8'h01))
        else $error("address moved by other than one");
    chk_write_resp: assert property ($rose(s_axi_bvalid) |->
        s_axi_bresp == (mapped ? vsra_pkg::RESP_OKAY : vsra_pkg::RESP_SLVERR))
        else $error("write response code wrong");
    cov_rom_read: cover property (rom_rd && !s_axi_rdata[25]);
    cov_kick_read: cover property ($rose(rom_out.req) && boot_done);
    cov_unmapped: cover property ($rose(s_axi_bvalid) && s_axi_bresp == vsra_pkg::RESP_SLVERR);
endmodule : vsra_checker

bind vsra_top vsra_checker u_vsra_checker (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .rom_detect, .rom_rsp, .rom_out, .boot_done);

// >>> tb/vsra_rom_model.sv
`timescale 1ns/1ps
module vsra_rom_model (
    input  wire logic               core_clk, // Clock
    input  wire logic               rst_b,    // Reset, low
    input  wire logic               slow,     // Stretch the answer
    input  vsra_pkg::vsra_rom_req_t rom_out,  // Request from block
    output vsra_pkg::vsra_rom_rsp_t rom_rsp   // Ack and byte
);
    logic [3:0] wait_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Four-phase answer, byte is address xor 5A; data line toggles when not held
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rom_rsp <= '0;
            wait_q  <= 4'h0;
        end else begin
            if (!rom_out.req || !rom_rsp.ack) rom_rsp.data <= ~rom_rsp.data;
            if (!rom_out.req) rom_rsp.ack <= 1'b0;
            if (rom_out.req && !rom_rsp.ack) begin
                wait_q <= wait_q + 4'h1;
                if (wait_q >= (slow ? 4'h9 : 4'h0)) begin
                    rom_rsp.ack  <= 1'b1;
                    rom_rsp.data <= rom_out.addr ^ 8'h5A;
                    wait_q       <= 4'h0;
                end
            end
        end
    end
endmodule : vsra_rom_model

// >>> tb/vsra_top_test.sv
`timescale 1ns/1ps
module vsra_top_test;
    logic                    core_clk      = 1'b0;
    logic                    rst_b         = 1'b0;
    logic [11:0]             s_axi_awaddr  = 12'h000;
    logic                    s_axi_awvalid = 1'b0;
    logic                    s_axi_awready;
    logic [31:0]             s_axi_wdata   = 32'h00000000;
    logic [3:0]              s_axi_wstrb   = 4'h0;
    logic                    s_axi_wvalid  = 1'b0;
    logic                    s_axi_wready;
    logic [1:0]              s_axi_bresp;
    logic                    s_axi_bvalid;
    logic                    s_axi_bready  = 1'b0;
    logic [11:0]             s_axi_araddr  = 12'h000;
    logic                    s_axi_arvalid = 1'b0;
    logic                    s_axi_arready;
    logic [31:0]             s_axi_rdata;
    logic [1:0]              s_axi_rresp;
    logic                    s_axi_rvalid;
    logic                    s_axi_rready  = 1'b0;
    logic                    rom_detect    = 1'b1;
    logic                    slow          = 1'b0;
    vsra_pkg::vsra_rom_rsp_t rom_rsp;
    vsra_pkg::vsra_rom_req_t rom_out;
    logic [127:0]            node_header;
    logic [31:0]             chip_config;
    logic                    boot_done;
    logic [31:0]             rd;
    int                      fail_count    = 0;
    int                      compares      = 0;

    vsra_top u_vsra_top (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rom_detect, .rom_rsp, .rom_out,
        .node_header, .chip_config, .boot_done);
    vsra_rom_model u_vsra_rom_model (.core_clk, .rst_b, .slow, .rom_out, .rom_rsp);

    always #25 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check32

    task automatic bound(input int n);
        if (n >= 1000) begin
            fail_count++;
            $display("ERROR %0t: wait ran out", $time);
            finish_test();
        end
    endtask : bound
    ////////////////////////////////////////////////////////////////////////////////
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] e);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 1000);
        bound(n);
        s_axi_bready <= 1'b0;
        check32({30'h0, s_axi_bresp}, {30'h0, e});
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 1000);
        bound(n);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check32({30'h0, s_axi_rresp}, {30'h0, e});
    endtask : axi_read

    task automatic do_reset(input logic fitted);
        int n;
        n = 0;
        @(posedge core_clk);
        rst_b      <= 1'b0;
        rom_detect <= fitted;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (!boot_done && n < 1000);
        bound(n);
    endtask : do_reset

    task automatic poll_done(input int b);
        int n;
        n = 0;
        do begin
            axi_read(vsra_pkg::ADDR_ROM_ACCESS, rd, vsra_pkg::RESP_OKAY);
            n++;
        end while (rd[b] && n < 1000);
        bound(n);
    endtask : poll_done
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_version();
        axi_read(vsra_pkg::ADDR_VERSION, rd, vsra_pkg::RESP_OKAY);
        check32(rd, {7'h00, rom_detect, 24'h010000});
        axi_write(vsra_pkg::ADDR_VERSION, 32'hFFFFFFFF, 4'hF, vsra_pkg::RESP_OKAY);
        axi_read(vsra_pkg::ADDR_VERSION, rd, vsra_pkg::RESP_OKAY);
        check32(rd, {7'h00, rom_detect, 24'h010000});
        axi_write(12'h008, 32'hFFFFFFFF, 4'hF, vsra_pkg::RESP_SLVERR);
        axi_read(12'h008, rd, vsra_pkg::RESP_SLVERR);
        check32(rd, 32'h00000000);
    endtask : test_version

    task automatic test_boot();
        for (int i = 0; i < 16; i++) begin
            check32({24'h0, node_header[8*i+:8]}, {24'h0, i[7:0] ^ 8'h5A});
        end
        for (int i = 0; i < 4; i++) begin
            check32({24'h0, chip_config[8*i+:8]}, {24'h0, 8'(i + 16) ^ 8'h5A});
        end
    endtask : test_boot

    task automatic test_walk(input logic s);
        slow <= s;
        axi_write(vsra_pkg::ADDR_ROM_ACCESS, 32'h80000000, 4'h8, vsra_pkg::RESP_OKAY);
        poll_done(31);
        for (int i = 0; i < 3; i++) begin
            axi_write(vsra_pkg::ADDR_ROM_ACCESS, 32'h02000000, 4'h8, vsra_pkg::RESP_OKAY);
            poll_done(25);
            check32(rd, {8'h00, i[7:0] ^ 8'h5A, 16'h0000});
        end
        axi_write(vsra_pkg::ADDR_ROM_ACCESS, 32'h82000000, 4'h8, vsra_pkg::RESP_OKAY);
        poll_done(25);
        check32(rd, {8'h00, 8'h5A, 16'h0000});
    endtask : test_walk

    task automatic test_zero_write();
        axi_write(vsra_pkg::ADDR_ROM_ACCESS, 32'h00000000, 4'hF, vsra_pkg::RESP_OKAY);
        axi_write(vsra_pkg::ADDR_ROM_ACCESS, 32'h82000000, 4'h7, vsra_pkg::RESP_OKAY);
        repeat (20) @(posedge core_clk);
        axi_read(vsra_pkg::ADDR_ROM_ACCESS, rd, vsra_pkg::RESP_OKAY);
        check32(rd, {8'h00, 8'h5A, 16'h0000});
    endtask : test_zero_write
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b1);
        test_version();
        test_boot();
        test_walk(1'b0);
        test_walk(1'b1);
        test_zero_write();
        do_reset(1'b0);
        test_version();
        finish_test();
    end
endmodule : vsra_top_test
